// File: rtl/xfer_pkg.sv
// constants and types for the memory transfer instruction group
// assumes: one 250 MHz clock, working registers and memory reached by ports
package xfer_pkg;

	// opcodes of the group
	localparam logic [7:0] OPC_PROG_CONST_LOAD    = 8'hC2;
	localparam logic [7:0] OPC_PROG_CONST_STORE   = 8'hD2;
	localparam logic [7:0] OPC_PROG_AUTOINC_LOAD  = 8'hC3;
	localparam logic [7:0] OPC_PROG_AUTOINC_STORE = 8'hD3;
	localparam logic [7:0] OPC_EXT_LOAD           = 8'h82;
	localparam logic [7:0] OPC_EXT_STORE          = 8'h92;
	localparam logic [7:0] OPC_EXT_AUTOINC_LOAD   = 8'h83;
	localparam logic [7:0] OPC_EXT_AUTOINC_STORE  = 8'h93;
	localparam logic [7:0] OPC_NO_OPERATION       = 8'hFF;

	// instruction lengths in clock cycles
	localparam logic [4:0] CYC_PROG_CONST = 5'h0C;
	localparam logic [4:0] CYC_AUTOINC    = 5'h12;
	localparam logic [4:0] CYC_EXT        = 5'h0C;
	localparam logic [4:0] CYC_NOP        = 5'h06;

	// step numbers within an instruction
	localparam logic [4:0] STEP_PAIR_HI  = 5'h00;
	localparam logic [4:0] STEP_PAIR_LO  = 5'h01;
	localparam logic [4:0] STEP_SINGLE   = 5'h02;
	localparam logic [4:0] STEP_FETCH_RF = 5'h03;
	localparam logic [4:0] STEP_MEM      = 5'h04;
	localparam logic [4:0] STEP_CAPTURE  = 5'h05;
	localparam logic [4:0] STEP_DEST     = 5'h06;
	localparam logic [4:0] STEP_PTR_WB   = 5'h07;
	localparam logic [4:0] STEP_LO_WB    = 5'h08;
	localparam logic [4:0] STEP_HI_WB    = 5'h09;

	// memory spaces on the memory port
	localparam logic SPACE_PROG = 1'b0;
	localparam logic SPACE_DATA = 1'b1;

	typedef enum logic [1:0] {
		KIND_NOP     = 2'b00,
		KIND_SINGLE  = 2'b01,
		KIND_AUTOINC = 2'b10
	} kind_e;

	typedef enum logic {
		RUN_IDLE = 1'b0,
		RUN_BUSY = 1'b1
	} run_e;

endpackage : xfer_pkg

// File: rtl/decode_if.sv
// decoded instruction fields passed from the decoder to the sequencer
// assumes: driven combinationally within the one clock domain
`timescale 1ns/1ns
`default_nettype none
interface decode_if;
	logic [7:0]          opcode;
	logic [7:0]          operand;
	logic                has_ext_prog;
	logic                has_ext_data;
	logic                known;
	logic                supported;
	xfer_pkg::kind_e     kind;
	logic                store;
	logic                space;
	logic [3:0]          single;
	logic [3:0]          pair;
	logic [4:0]          last;

	modport decoder (input opcode, operand, has_ext_prog, has_ext_data,
		output known, supported, kind, store, space, single, pair, last);
	modport sequencer (output opcode, operand, has_ext_prog, has_ext_data,
		input known, supported, kind, store, space, single, pair, last);
endinterface : decode_if
`default_nettype wire

// File: rtl/xfer_decode.sv
// opcode and operand decoder for the memory transfer group
// assumes: purely combinational, fed from the sequencer's issue port
`timescale 1ns/1ns
`default_nettype none
module xfer_decode (
	// decoded fields
	decode_if.decoder dec
);
	logic [4:0] length;

	always_comb begin
		dec.known = 1'b1;
		dec.kind  = xfer_pkg::KIND_SINGLE;
		dec.store = 1'b0;
		dec.space = xfer_pkg::SPACE_PROG;
		length    = xfer_pkg::CYC_PROG_CONST;
		unique case (dec.opcode)
			xfer_pkg::OPC_PROG_CONST_LOAD: begin
			end
			xfer_pkg::OPC_PROG_CONST_STORE: begin
				dec.store = 1'b1;
			end
			xfer_pkg::OPC_PROG_AUTOINC_LOAD: begin
				dec.kind = xfer_pkg::KIND_AUTOINC;
				length   = xfer_pkg::CYC_AUTOINC;
			end
			xfer_pkg::OPC_PROG_AUTOINC_STORE: begin
				dec.kind  = xfer_pkg::KIND_AUTOINC;
				dec.store = 1'b1;
				length    = xfer_pkg::CYC_AUTOINC;
			end
			xfer_pkg::OPC_EXT_LOAD: begin
				dec.space = xfer_pkg::SPACE_DATA;
				length    = xfer_pkg::CYC_EXT;
			end
			xfer_pkg::OPC_EXT_STORE: begin
				dec.space = xfer_pkg::SPACE_DATA;
				dec.store = 1'b1;
				length    = xfer_pkg::CYC_EXT;
			end
			xfer_pkg::OPC_EXT_AUTOINC_LOAD: begin
				dec.kind  = xfer_pkg::KIND_AUTOINC;
				dec.space = xfer_pkg::SPACE_DATA;
				length    = xfer_pkg::CYC_AUTOINC;
			end
			xfer_pkg::OPC_EXT_AUTOINC_STORE: begin
				dec.kind  = xfer_pkg::KIND_AUTOINC;
				dec.space = xfer_pkg::SPACE_DATA;
				dec.store = 1'b1;
				length    = xfer_pkg::CYC_AUTOINC;
			end
			xfer_pkg::OPC_NO_OPERATION: begin
				dec.kind = xfer_pkg::KIND_NOP;
				length   = xfer_pkg::CYC_NOP;
			end
			default: begin
				dec.known = 1'b0;
			end
		endcase
		dec.last = 5'(length - 5'h01);
	end

	// program store needs external program space, data forms external data
	assign dec.supported = dec.known
		&& !(dec.kind != xfer_pkg::KIND_NOP && dec.space == xfer_pkg::SPACE_PROG
			&& dec.store && !dec.has_ext_prog)
		&& !(dec.kind != xfer_pkg::KIND_NOP && dec.space == xfer_pkg::SPACE_DATA
			&& !dec.has_ext_data);

	// single register in high nibble, pair in low nibble, both directions
	assign dec.single = dec.operand[7:4];
	assign dec.pair   = dec.operand[3:0];

endmodule : xfer_decode
`default_nettype wire

// File: rtl/memory_transfer_instr_exec.sv
// sequencer for program-memory and external-data transfers and no-operation
// assumes: same-clock issue logic, register reads answer in the same cycle,
// memory read data valid one cycle after the read strobe
//
// Function
// - constant store writes named register byte to program address in pair
// - program store allowed only when external program space exists
// - program autoincrement transfers take 18 cycles, C3 load, D3 store
// - autoincrement adds one to register pointer and to pair address
// - external single transfers take 12 cycles, 82 load, 92 store
// - external autoincrement transfers take 18 cycles, 83 load, 93 store
// - external data forms allowed only when external data space exists
// - source never written, flags never touched
// - FF does nothing for 6 cycles and strobes no port
`timescale 1ns/1ns
`default_nettype none
module memory_transfer_instr_exec (
	// clock and reset
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic        ce,
	// device variant
	input  wire logic        has_ext_prog,
	input  wire logic        has_ext_data,
	// instruction issue
	input  wire logic        start,
	input  wire logic [7:0]  opcode,
	input  wire logic [7:0]  operand,
	output logic             ready,
	output logic             refused,
	output logic             instr_done,
	// working registers
	output logic [3:0]       work_addr,
	input  wire logic [7:0]  work_rdata,
	output logic             work_wr,
	output logic [7:0]       work_wdata,
	// register file
	output logic [7:0]       rf_addr,
	input  wire logic [7:0]  rf_rdata,
	output logic             rf_wr,
	output logic [7:0]       rf_wdata,
	// program and external data memory
	output logic             mem_space,
	output logic [15:0]      mem_addr,
	output logic             mem_rd,
	output logic             mem_wr,
	output logic [7:0]       mem_wdata,
	input  wire logic [7:0]  mem_rdata
);
	typedef struct packed {
		xfer_pkg::run_e  run;
		logic [4:0]      step;
		logic [4:0]      last;
		xfer_pkg::kind_e kind;
		logic [7:0]      opcode;
		logic            store;
		logic            space;
		logic [3:0]      single;
		logic [3:0]      pair;
		logic [15:0]     addr;
		logic [7:0]      ptr;
		logic [7:0]      data;
	} state_s;

	state_s   s;
	state_s   next_s;
	decode_if dec ();

	assign dec.opcode       = opcode;
	assign dec.operand      = operand;
	assign dec.has_ext_prog = has_ext_prog;
	assign dec.has_ext_data = has_ext_data;

	xfer_decode u_decode (
		.dec (dec)
	);

	logic busy;
	logic accept;
	logic autoinc;
	logic active;

	assign busy       = s.run == xfer_pkg::RUN_BUSY;
	assign ready      = !busy;
	assign accept     = start && !busy && dec.supported;
	assign refused    = start && !busy && !dec.supported;
	assign instr_done = busy && s.step == s.last;
	assign autoinc    = s.kind == xfer_pkg::KIND_AUTOINC;
	assign active     = busy && s.kind != xfer_pkg::KIND_NOP;

	// pair high byte sits in the even register of the pair
	always_comb begin
		work_addr  = s.single;
		work_wr    = 1'b0;
		work_wdata = s.data;
		rf_addr    = s.ptr;
		rf_wr      = 1'b0;
		rf_wdata   = s.data;
		mem_rd     = 1'b0;
		mem_wr     = 1'b0;
		if (active) begin
			unique case (s.step)
				xfer_pkg::STEP_PAIR_HI: work_addr = {s.pair[3:1], 1'b0};
				xfer_pkg::STEP_PAIR_LO: work_addr = {s.pair[3:1], 1'b1};
				xfer_pkg::STEP_MEM: begin
					mem_rd = !s.store;
					mem_wr = s.store;
				end
				xfer_pkg::STEP_DEST: begin
					// only the destination is written
					work_wr = !s.store && !autoinc;
					rf_wr   = !s.store && autoinc;
				end
				xfer_pkg::STEP_PTR_WB: begin
					work_wr    = autoinc;
					work_wdata = s.ptr;
				end
				xfer_pkg::STEP_LO_WB: begin
					work_addr  = {s.pair[3:1], 1'b1};
					work_wr    = autoinc;
					work_wdata = s.addr[7:0];
				end
				xfer_pkg::STEP_HI_WB: begin
					work_addr  = {s.pair[3:1], 1'b0};
					work_wr    = autoinc;
					work_wdata = s.addr[15:8];
				end
				default: begin
				end
			endcase
		end
	end

	assign mem_space = s.space;
	assign mem_addr  = s.addr;
	assign mem_wdata = s.data;

	always_comb begin
		next_s = s;
		if (accept) begin
			next_s.run    = xfer_pkg::RUN_BUSY;
			next_s.step   = 5'h00;
			next_s.last   = dec.last;
			next_s.kind   = dec.kind;
			next_s.opcode = opcode;
			next_s.store  = dec.store;
			next_s.space  = dec.space;
			next_s.single = dec.single;
			next_s.pair   = dec.pair;
		end else if (busy) begin
			next_s.step = 5'(s.step + 5'h01);
			if (instr_done) begin
				next_s.run = xfer_pkg::RUN_IDLE;
			end
			if (active) begin
				unique case (s.step)
					xfer_pkg::STEP_PAIR_HI: next_s.addr[15:8] = work_rdata;
					xfer_pkg::STEP_PAIR_LO: next_s.addr[7:0] = work_rdata;
					xfer_pkg::STEP_SINGLE: begin
						if (autoinc) begin
							next_s.ptr = work_rdata;
						end else if (s.store) begin
							next_s.data = work_rdata;
						end
					end
					xfer_pkg::STEP_FETCH_RF: begin
						if (autoinc && s.store) begin
							next_s.data = rf_rdata;
						end
					end
					xfer_pkg::STEP_CAPTURE: begin
						if (!s.store) begin
							next_s.data = mem_rdata;
						end
					end
					xfer_pkg::STEP_DEST: begin
						// both pointers advance whatever the direction
						if (autoinc) begin
							next_s.ptr  = 8'(s.ptr + 8'h01);
							next_s.addr = 16'(s.addr + 16'h0001);
						end
					end
					default: begin
					end
				endcase
			end
		end
	end

	// low clock enable freezes the whole sequence
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
		end else if (ce) begin
			s <= next_s;
		end
	end

	pair_field_a: assert property (@(posedge clock) disable iff (!rst_n)
		accept && ce |=> s.pair == $past(operand[3:0]) && s.single == $past(operand[7:4]))
		else $error("register fields taken from wrong nibbles");

	const_store_a: assert property (@(posedge clock) disable iff (!rst_n)
		busy && s.opcode == 8'hD2 && s.step == 5'h04 |->
		mem_wr && mem_space == 1'b0 && !work_wr && !rf_wr)
		else $error("program store strobe missing");

	prog_gate_a: assert property (@(posedge clock) disable iff (!rst_n)
		mem_wr && mem_space == 1'b0 |-> has_ext_prog)
		else $error("program store without external program space");

	prog_auto_len_a: assert property (@(posedge clock) disable iff (!rst_n)
		instr_done && (s.opcode == xfer_pkg::OPC_PROG_AUTOINC_LOAD
			|| s.opcode == xfer_pkg::OPC_PROG_AUTOINC_STORE)
		|-> s.step == 5'(xfer_pkg::CYC_AUTOINC - 5'h01))
		else $error("program autoincrement not 18 cycles");

	ptr_step_a: assert property (@(posedge clock) disable iff (!rst_n)
		busy && autoinc && s.step == xfer_pkg::STEP_PTR_WB && $past(ce) |->
		work_wr && work_wdata == 8'($past(s.ptr) + 8'h01))
		else $error("register pointer not advanced by one");

	pair_step_a: assert property (@(posedge clock) disable iff (!rst_n)
		busy && autoinc && s.step == xfer_pkg::STEP_HI_WB
		&& $past(s.step, 3) == xfer_pkg::STEP_DEST |->
		work_wr && s.addr == 16'($past(s.addr, 3) + 16'h0001))
		else $error("pair address not advanced by one");

	ext_len_a: assert property (@(posedge clock) disable iff (!rst_n)
		instr_done && (s.opcode == xfer_pkg::OPC_EXT_LOAD || s.opcode == xfer_pkg::OPC_EXT_STORE)
		|-> s.step == 5'(xfer_pkg::CYC_EXT - 5'h01))
		else $error("external transfer not 12 cycles");

	ext_auto_len_a: assert property (@(posedge clock) disable iff (!rst_n)
		instr_done && (s.opcode == xfer_pkg::OPC_EXT_AUTOINC_LOAD
			|| s.opcode == xfer_pkg::OPC_EXT_AUTOINC_STORE)
		|-> s.step == 5'(xfer_pkg::CYC_AUTOINC - 5'h01))
		else $error("external autoincrement not 18 cycles");

	ext_gate_a: assert property (@(posedge clock) disable iff (!rst_n)
		(mem_rd || mem_wr) && mem_space == 1'b1 |-> has_ext_data)
		else $error("external data access without external data space");

	src_kept_a: assert property (@(posedge clock) disable iff (!rst_n)
		busy && s.store |-> !rf_wr && !(work_wr && s.step < 5'h07))
		else $error("store wrote its source");

	nop_quiet_a: assert property (@(posedge clock) disable iff (!rst_n)
		busy && s.opcode == xfer_pkg::OPC_NO_OPERATION |->
		!work_wr && !rf_wr && !mem_rd && !mem_wr
		&& instr_done == (s.step == 5'(xfer_pkg::CYC_NOP - 5'h01)))
		else $error("no-operation not quiet for 6 cycles");

endmodule : memory_transfer_instr_exec
`default_nettype wire

// File: tb/xfer_mem_model.sv
// working registers, register file and both memory spaces seen by the sequencer
// assumes: one clock, writes land at the strobe edge, memory read data one cycle late
`timescale 1ns/1ns
`default_nettype none
module xfer_mem_model (
	// clock
	input  wire logic        clock,
	// working registers
	input  wire logic [3:0]  work_addr,
	output logic      [7:0]  work_rdata,
	input  wire logic        work_wr,
	input  wire logic [7:0]  work_wdata,
	// register file
	input  wire logic [7:0]  rf_addr,
	output logic      [7:0]  rf_rdata,
	input  wire logic        rf_wr,
	input  wire logic [7:0]  rf_wdata,
	// memories
	input  wire logic        mem_space,
	input  wire logic [15:0] mem_addr,
	input  wire logic        mem_rd,
	input  wire logic        mem_wr,
	input  wire logic [7:0]  mem_wdata,
	output logic      [7:0]  mem_rdata
);
	logic [7:0] work [0:15];
	logic [7:0] rf   [0:255];
	logic [7:0] mem  [0:1][0:65535];
	logic [7:0] rd_q = 8'h5A;

	assign work_rdata = work[work_addr];
	assign rf_rdata   = rf[rf_addr];
	assign mem_rdata  = rd_q;

	// outside the read slot the bus toggles, never a stale byte
	always @(posedge clock) begin
		if (mem_rd)
			rd_q <= mem[mem_space][mem_addr];
		else
			rd_q <= ~rd_q;
		if (mem_wr)
			mem[mem_space][mem_addr] <= mem_wdata;
		if (work_wr)
			work[work_addr] <= work_wdata;
		if (rf_wr)
			rf[rf_addr] <= rf_wdata;
	end
endmodule : xfer_mem_model
`default_nettype wire

// File: tb/tb.sv
// self-checking bench for the memory transfer sequencer
// assumes: xfer_mem_model stands for registers and memories
`timescale 1ns/1ns
`default_nettype none
module tb;
	logic        clock, rst_n, ce, has_ext_prog, has_ext_data, start;
	logic [7:0]  opcode, operand, work_rdata, work_wdata, rf_addr, rf_rdata, rf_wdata;
	logic        ready, refused, instr_done, work_wr, rf_wr, mem_space, mem_rd, mem_wr;
	logic [3:0]  work_addr;
	logic [15:0] mem_addr;
	logic [7:0]  mem_wdata, mem_rdata;
	int          fail_count, checked, strobes;

	memory_transfer_instr_exec memory_transfer_instr_exec_i (.clock, .rst_n, .ce,
		.has_ext_prog, .has_ext_data, .start, .opcode, .operand, .ready, .refused,
		.instr_done, .work_addr, .work_rdata, .work_wr, .work_wdata, .rf_addr, .rf_rdata,
		.rf_wr, .rf_wdata, .mem_space, .mem_addr, .mem_rd, .mem_wr, .mem_wdata, .mem_rdata);
	xfer_mem_model xfer_mem_model_i (.clock, .work_addr, .work_rdata, .work_wr, .work_wdata,
		.rf_addr, .rf_rdata, .rf_wr, .rf_wdata, .mem_space, .mem_addr, .mem_rd, .mem_wr,
		.mem_wdata, .mem_rdata);

	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end

	always @(posedge clock) begin
		if (work_wr | rf_wr | mem_wr | mem_rd)
			strobes++;
	end

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : report_and_stop

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// issue one instruction, optionally freeze ce, and time it to instr_done
	task automatic run(input logic [7:0] op, input logic [7:0] opr, input int n, input int fz);
		int k;
		@(negedge clock);
		start   = 1'b1;
		opcode  = op;
		operand = opr;
		@(negedge clock);
		start = 1'b0;
		check("busy", 16'(ready), 16'h0000);
		if (fz > 0) begin
			ce = 1'b0;
			repeat (fz) @(negedge clock);
			ce = 1'b1;
		end
		k = fz;
		while (instr_done !== 1'b1) begin
			@(negedge clock);
			k++;
			if (k > 40) begin
				fail_count++;
				report_and_stop();
			end
		end
		check("cycles", 16'(k), 16'(n - 1 + fz));
	endtask : run

	task automatic t_single();
		logic [7:0]  op [4] = '{8'hC2, 8'hD2, 8'h82, 8'h92};
		logic [15:0] a;
		logic        sp;
		for (int i = 0; i < 4; i++) begin
			sp = !op[i][6];
			a = 16'h10A2 + 16'(i);
			xfer_mem_model_i.work[4'h4] = 8'h5C;
			xfer_mem_model_i.work[4'hA] = a[15:8];
			xfer_mem_model_i.work[4'hB] = a[7:0];
			xfer_mem_model_i.mem[sp][a] = 8'h22;
			run(op[i], 8'h4A, 12, 0);
			check("mem", 16'(xfer_mem_model_i.mem[sp][a]), op[i][4] ? 16'h005C : 16'h0022);
			check("work", 16'(xfer_mem_model_i.work[4'h4]), op[i][4] ? 16'h005C : 16'h0022);
			check("pair", {xfer_mem_model_i.work[4'hA], xfer_mem_model_i.work[4'hB]}, a);
		end
		$display("test single done");
	endtask : t_single

	task automatic t_autoinc();
		logic [7:0] op [4] = '{8'hC3, 8'hD3, 8'h83, 8'h93};
		logic       sp;
		logic       st;
		for (int i = 0; i < 4; i++) begin
			sp = !op[i][6];
			st = op[i][4];
			xfer_mem_model_i.work[4'h2] = 8'h20;
			xfer_mem_model_i.work[4'h6] = 8'h30;
			xfer_mem_model_i.work[4'h7] = 8'hFF;
			xfer_mem_model_i.rf[8'h20] = st ? 8'hA1 : 8'h00;
			xfer_mem_model_i.rf[8'h21] = st ? 8'hB2 : 8'h00;
			xfer_mem_model_i.mem[sp][16'h30FF] = st ? 8'h00 : 8'hA1;
			xfer_mem_model_i.mem[sp][16'h3100] = st ? 8'h00 : 8'hB2;
			run(op[i], 8'h26, 18, 0);
			run(op[i], 8'h26, 18, 0);
			check("rf lo", 16'(xfer_mem_model_i.rf[8'h20]), 16'h00A1);
			check("rf hi", 16'(xfer_mem_model_i.rf[8'h21]), 16'h00B2);
			check("mem lo", 16'(xfer_mem_model_i.mem[sp][16'h30FF]), 16'h00A1);
			check("mem hi", 16'(xfer_mem_model_i.mem[sp][16'h3100]), 16'h00B2);
			check("ptr", 16'(xfer_mem_model_i.work[4'h2]), 16'h0022);
			check("pair", {xfer_mem_model_i.work[4'h6], xfer_mem_model_i.work[4'h7]}, 16'h3101);
		end
		$display("test autoinc done");
	endtask : t_autoinc

	task automatic t_nop();
		int s;
		s = strobes;
		run(8'hFF, 8'h26, 6, 0);
		run(8'hFF, 8'h26, 6, 3);
		check("nop strobes", 16'(strobes - s), 16'h0000);
		$display("test nop done");
	endtask : t_nop

	task automatic t_refuse();
		logic [7:0] op [7] = '{8'hD2, 8'hD3, 8'h82, 8'h92, 8'h83, 8'h93, 8'h12};
		int         s;
		s = strobes;
		for (int i = 0; i < 7; i++) begin
			@(negedge clock);
			has_ext_prog = (i >= 2);
			has_ext_data = (i < 2) || (i == 6);
			start = 1'b1;
			opcode = op[i];
			operand = 8'h26;
			#1;
			check("refused", 16'(refused), 16'h0001);
			@(negedge clock);
			start = 1'b0;
			check("idle", 16'(ready), 16'h0001);
		end
		check("refuse strobes", 16'(strobes - s), 16'h0000);
		// program loads need no external program space
		has_ext_prog = 1'b0;
		run(8'hC2, 8'h4A, 12, 0);
		has_ext_prog = 1'b1;
		has_ext_data = 1'b1;
		$display("test refuse done");
	endtask : t_refuse

	initial begin
		rst_n = 1'b0;
		ce = 1'b1;
		has_ext_prog = 1'b1;
		has_ext_data = 1'b1;
		start = 1'b0;
		opcode = 8'h00;
		operand = 8'h00;
		repeat (4) @(negedge clock);
		check("reset ready", 16'(ready), 16'h0001);
		rst_n = 1'b1;
		t_single();
		t_autoinc();
		t_nop();
		t_refuse();
		report_and_stop();
	end
endmodule : tb
`default_nettype wire
